// ===== pkg/cfg_loader_pkg.sv
// Purpose: shared constants for the parallel configuration loader, both ends
// Assumes: clock_in at 100 MHz on both ends
// Notes:   times are kept in their own units, cycle counts derived from them
package cfg_loader_pkg;
  localparam int          CLK_MHZ            = 100;
  localparam int          DATA_W             = 32;
  localparam int          MODE_W             = 4;
  localparam int          TMR_W              = 24;
  localparam int          UCNT_W             = 14;
  // mode select pin fields
  localparam int          MODE_WIDTH_LSB     = 0;
  localparam int          MODE_POR_FAST_BIT  = 2;
  localparam int          MODE_VOLT_BIT      = 3;
  localparam logic [1:0]  WIDTH_X8           = 2'h0;
  localparam logic [1:0]  WIDTH_X16          = 2'h1;
  localparam logic [1:0]  WIDTH_X32          = 2'h2;
  // power-up hold, least figures used
  localparam int          POR_FAST_MIN_MS    = 4;
  localparam int          POR_FAST_MAX_MS    = 12;
  localparam int          POR_STD_MIN_MS     = 100;
  localparam int          POR_STD_MAX_MS     = 300;
  localparam int          POR_FAST_CYC       = POR_FAST_MIN_MS * 1000 * CLK_MHZ;
  localparam int          POR_STD_CYC        = POR_STD_MIN_MS * 1000 * CLK_MHZ;
  // complete-to-user-mode timing
  localparam int          CD2UM_MIN_US       = 175;
  localparam int          CD2UM_MAX_US       = 437;
  localparam int          CD2UM_CYC          = CD2UM_MIN_US * CLK_MHZ;
  localparam int          MAX_CFG_CLK_NS     = 160;
  localparam int          CD2CU_PERIODS      = 4;
  localparam int          CD2CU_CYC          = (CD2CU_PERIODS * MAX_CFG_CLK_NS * CLK_MHZ + 999) / 1000;
  localparam int          USER_INIT_PERIODS  = 8576;
  localparam int          POST_DONE_EDGES    = 2;
  // stream length and host timing
  localparam int          CFG_BYTES          = 64;
  localparam int          CLK_DIV_HALF       = 8;
  localparam int          REQ_LOW_CYC        = 16;
  // host register map
  localparam logic [7:0]  REG_CTRL           = 8'h00;
  localparam logic [7:0]  REG_CMD            = 8'h04;
  localparam logic [7:0]  REG_DATA           = 8'h08;
  localparam logic [7:0]  REG_STAT           = 8'h0C;
  localparam int          CTRL_W             = 6;
  localparam int          CTRL_DECOMP_BIT    = 4;
  localparam int          CTRL_SEC_BIT       = 5;
  localparam int          CMD_START_BIT      = 0;
  localparam int          STAT_STATUS_BIT    = 0;
  localparam int          STAT_DONE_BIT      = 1;
  localparam int          STAT_BUSY_BIT      = 2;
  localparam int          STAT_READY_BIT     = 3;

  function automatic logic [3:0] ratio_f(input logic [1:0] w, input logic dec, input logic sec);
    case (w)
      WIDTH_X8:  ratio_f = dec ? 4'h2 : 4'h1;
      WIDTH_X16: ratio_f = dec ? 4'h4 : (sec ? 4'h2 : 4'h1);
      WIDTH_X32: ratio_f = dec ? 4'h8 : (sec ? 4'h4 : 4'h1);
      default:   ratio_f = 4'h1;
    endcase
  endfunction

  function automatic logic [2:0] bytes_f(input logic [1:0] w);
    case (w)
      WIDTH_X16: bytes_f = 3'h2;
      WIDTH_X32: bytes_f = 3'h4;
      default:   bytes_f = 3'h1;
    endcase
  endfunction

  function automatic logic [31:0] mask_f(input logic [1:0] w);
    case (w)
      WIDTH_X16: mask_f = 32'h0000FFFF;
      WIDTH_X32: mask_f = 32'hFFFFFFFF;
      default:   mask_f = 32'h000000FF;
    endcase
  endfunction
endpackage

// ===== pkg/cfg_link_if.sv
// Purpose: pins between configuration host and loading device
// Assumes: open-drain lines pulled up
// Notes:   wire levels are resolved here from the output enables
`timescale 1ns/1ps
interface cfg_link_if;
  logic        config_clock;
  logic [31:0] config_data;
  logic        config_request_n;
  logic [3:0]  mode_select_pins;
  logic        chip_enable_in_n;
  logic        chain_enable_out_n;
  logic        status_val;
  logic        status_oe;
  logic        complete_val;
  logic        complete_oe;
  logic        config_status_n;
  logic        config_complete;

  assign config_status_n = status_oe   ? status_val   : 1'b1;
  assign config_complete = complete_oe ? complete_val : 1'b1;

  modport device (
    input  config_clock, config_data, config_request_n, mode_select_pins, chip_enable_in_n,
    input  config_status_n, config_complete,
    output chain_enable_out_n, status_val, status_oe, complete_val, complete_oe
  );
  modport host (
    output config_clock, config_data, config_request_n, mode_select_pins, chip_enable_in_n,
    input  config_status_n, config_complete, chain_enable_out_n
  );
endinterface

// ===== hw/cfg_load_device.sv
// Purpose: device end of the fast parallel load port
// Assumes: config_clock comes from the host; clock_in is the internal oscillator
// Notes:   link capture runs on config_clock, sequencing on clock_in
//
// Behaviour
// R1: mode pins pick width, voltage, hold class
// R2: only the lanes of chosen width carry data
// R3: clock-to-data ratio from width and features
// R4: host clocks r times per held value
// R5: one value per r clocks, rest processing
// R6: host clocks r-1 more after last value
// R7: status held low for hold, then released
// R8: hold is fast or standard per pins
// R9: oscillator init reaches user mode in window
// R10: user init clock enabled after four periods
// R11: user mode after 8576 user clock periods
// R12: complete low until whole stream received
// R13: two falling clock edges start initialization
// R14: request low restarts configuration from any state but power-up hold
// R15: data sampled at first rising edge per group
`timescale 1ns/1ps
module cfg_load_device
  import cfg_loader_pkg::*;
#(
  parameter logic [TMR_W-1:0]  POR_FAST_CYC_P      = TMR_W'(POR_FAST_CYC),
  parameter logic [TMR_W-1:0]  POR_STD_CYC_P       = TMR_W'(POR_STD_CYC),
  parameter logic [TMR_W-1:0]  CD2UM_CYC_P         = TMR_W'(CD2UM_CYC),
  parameter logic [UCNT_W-1:0] USER_INIT_PERIODS_P = UCNT_W'(USER_INIT_PERIODS)
) (
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  input  wire logic        decompress_en_in,
  input  wire logic        security_en_in,
  input  wire logic        user_init_opt_in,
  input  wire logic        user_init_clock_in,
  output logic             user_mode_out,
  output logic             io_voltage_sel_out,
  output logic [31:0]      config_word_out,
  output logic             config_word_valid_out,
  cfg_link_if.device       link
);

  typedef enum logic [2:0] {ST_POR, ST_HOLD, ST_LOAD, ST_INIT, ST_USER} dev_state_t;

  // ---------------------------------------------------------------
  // oscillator domain synchronisers
  // ---------------------------------------------------------------
  localparam int OS_W = 10;
  logic [OS_W-1:0]   os1_r;
  logic [OS_W-1:0]   os2_r;
  logic [MODE_W-1:0] mode_s;
  logic [1:0]        feat_s;
  logic              req_n_s;
  logic              done_s;
  logic              uclk_s;
  logic              cclk_s;
  logic              done_lnk_r;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      os1_r <= '0;
      os2_r <= '0;
    end else if (ce_in) begin
      os1_r <= {decompress_en_in, security_en_in, link.mode_select_pins, link.config_request_n,
                done_lnk_r, user_init_clock_in, link.config_clock};
      os2_r <= os1_r;
    end
  end
  assign {feat_s, mode_s, req_n_s, done_s, uclk_s, cclk_s} = os2_r;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  dev_state_t        state_r, state_nxt;
  logic [TMR_W-1:0]  tmr_r, tmr_nxt;
  logic [UCNT_W-1:0] ucnt_r, ucnt_nxt;
  logic [1:0]        edges_r, edges_nxt;
  logic [MODE_W-1:0] mode_r, mode_nxt;
  logic [1:0]        feat_r, feat_nxt;
  logic              cclk_d_r, uclk_d_r;
  logic              uen_r, uen_nxt;
  logic              status_oe_r, complete_oe_r, user_r, chain_n_r, load_en_r;
  logic [TMR_W-1:0]  por_lim;
  logic              init_ok;

  always_comb begin
    por_lim   = mode_r[MODE_POR_FAST_BIT] ? POR_FAST_CYC_P : POR_STD_CYC_P; // R8
    state_nxt = state_r;
    tmr_nxt   = tmr_r;
    ucnt_nxt  = ucnt_r;
    edges_nxt = edges_r;
    mode_nxt  = mode_r;
    feat_nxt  = feat_r;
    uen_nxt   = uen_r;
    init_ok   = 1'b0;
    case (state_r)
      ST_POR: begin
        mode_nxt = mode_s; // R1
        feat_nxt = feat_s;
        if (tmr_r >= por_lim - 1'b1) begin // R7
          state_nxt = ST_LOAD;
          tmr_nxt   = '0;
        end else begin
          tmr_nxt = tmr_r + 1'b1;
        end
      end
      ST_HOLD: begin
        mode_nxt = mode_s;
        feat_nxt = feat_s;
        if (req_n_s) begin
          state_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (done_s) begin // R12
          state_nxt = ST_INIT;
          tmr_nxt   = '0;
          ucnt_nxt  = '0;
          edges_nxt = '0;
          uen_nxt   = 1'b0;
        end
      end
      ST_INIT: begin
        if (tmr_r != {TMR_W{1'b1}}) begin
          tmr_nxt = tmr_r + 1'b1;
        end
        if (cclk_d_r && !cclk_s && edges_r != 2'(POST_DONE_EDGES)) begin // R13
          edges_nxt = edges_r + 1'b1;
        end
        if (user_init_opt_in && tmr_r >= TMR_W'(CD2CU_CYC - 1)) begin // R10
          uen_nxt = 1'b1;
        end
        if (uen_r && uclk_s && !uclk_d_r && ucnt_r != USER_INIT_PERIODS_P + 1'b1) begin // first edge opens count
          ucnt_nxt = ucnt_r + 1'b1;
        end
        init_ok = user_init_opt_in ? (ucnt_r == USER_INIT_PERIODS_P + 1'b1) // R11
                                   : (tmr_r >= CD2UM_CYC_P - 1'b1); // R9
        if (init_ok && edges_r == 2'(POST_DONE_EDGES)) begin
          state_nxt = ST_USER;
        end
      end
      ST_USER: begin
        state_nxt = ST_USER;
      end
      default: begin
        state_nxt = ST_POR;
      end
    endcase
    if (!req_n_s && state_r != ST_POR) begin // R14
      state_nxt = ST_HOLD;
      tmr_nxt   = '0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r       <= ST_POR;
      tmr_r         <= '0;
      ucnt_r        <= '0;
      edges_r       <= '0;
      mode_r        <= '0;
      feat_r        <= '0;
      uen_r         <= 1'b0;
      cclk_d_r      <= 1'b0;
      uclk_d_r      <= 1'b0;
      status_oe_r   <= 1'b1;
      complete_oe_r <= 1'b1;
      user_r        <= 1'b0;
      chain_n_r     <= 1'b1;
      load_en_r     <= 1'b0;
    end else if (ce_in) begin
      state_r       <= state_nxt;
      tmr_r         <= tmr_nxt;
      ucnt_r        <= ucnt_nxt;
      edges_r       <= edges_nxt;
      mode_r        <= mode_nxt;
      feat_r        <= feat_nxt;
      uen_r         <= uen_nxt;
      cclk_d_r      <= cclk_s;
      uclk_d_r      <= uclk_s;
      status_oe_r   <= (state_nxt == ST_POR) || (state_nxt == ST_HOLD); // R7
      complete_oe_r <= (state_nxt != ST_INIT) && (state_nxt != ST_USER); // R12
      user_r        <= (state_nxt == ST_USER);
      chain_n_r     <= (state_nxt != ST_INIT) && (state_nxt != ST_USER);
      load_en_r     <= (state_nxt == ST_LOAD);
    end
  end

  assign link.status_val         = 1'b0;
  assign link.status_oe          = status_oe_r;
  assign link.complete_val       = 1'b0;
  assign link.complete_oe        = complete_oe_r;
  assign link.chain_enable_out_n = chain_n_r;
  assign user_mode_out           = user_r;
  assign io_voltage_sel_out      = mode_r[MODE_VOLT_BIT];

  // ---------------------------------------------------------------
  // link domain synchronisers
  // ---------------------------------------------------------------
  // cleared outside loading, also while the host clocks the post-done edges; settings stay still while loading
  localparam int LS_W = 2;
  logic [LS_W-1:0] ls1_r;
  logic [LS_W-1:0] ls2_r;
  logic            lnk_rst_n, ce_s, dec_s, sec_s, cen_n_s;
  logic [1:0]      width_s;

  assign lnk_rst_n = rst_b_in & load_en_r;

  always_ff @(posedge link.config_clock or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      ls1_r <= 2'h2;
      ls2_r <= 2'h2;
    end else begin
      ls1_r <= {ce_in, link.chip_enable_in_n};
      ls2_r <= ls1_r;
    end
  end
  assign {ce_s, cen_n_s} = ls2_r;
  assign width_s         = mode_r[MODE_WIDTH_LSB +: 2];
  assign {dec_s, sec_s}  = feat_r;

  // ---------------------------------------------------------------
  // link capture
  // ---------------------------------------------------------------
  logic [3:0]  ratio;
  logic [2:0]  phase_r, phase_nxt;
  logic [7:0]  bytes_r, bytes_nxt;
  logic        done_nxt;
  logic [31:0] word_r, word_nxt;
  logic        valid_r, valid_nxt;

  always_comb begin
    ratio     = ratio_f(width_s, dec_s, sec_s); // R3
    phase_nxt = phase_r;
    bytes_nxt = bytes_r;
    done_nxt  = done_lnk_r;
    word_nxt  = word_r;
    valid_nxt = 1'b0;
    if (ce_s && !done_lnk_r && !cen_n_s) begin
      if (phase_r == 3'h0) begin // R15
        word_nxt  = link.config_data & mask_f(width_s); // R2
        valid_nxt = 1'b1;
        bytes_nxt = bytes_r + 8'(bytes_f(width_s));
      end
      phase_nxt = (4'(phase_r) == ratio - 4'h1) ? 3'h0 : phase_r + 3'h1; // R5
      done_nxt  = (phase_nxt == 3'h0) && (bytes_nxt >= 8'(CFG_BYTES)); // R6
    end
  end

  always_ff @(posedge link.config_clock or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      phase_r    <= '0;
      bytes_r    <= '0;
      done_lnk_r <= 1'b0;
      word_r     <= '0;
      valid_r    <= 1'b0;
    end else begin
      phase_r    <= phase_nxt;
      bytes_r    <= bytes_nxt;
      done_lnk_r <= done_nxt;
      word_r     <= word_nxt;
      valid_r    <= valid_nxt;
    end
  end

  assign config_word_out       = word_r;
  assign config_word_valid_out = valid_r;

endmodule

// ===== hw/cfg_load_host.sv
// Purpose: configuration host end, driven by software over APB
// Assumes: clock_in at 100 MHz; config_clock made here by a divider
// Notes:   data register write stalls pready until the link can take it
`timescale 1ns/1ps
module cfg_load_host
  import cfg_loader_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  cfg_link_if.host         link
);

  typedef enum logic [2:0] {H_IDLE, H_REQ, H_WAIT, H_READY, H_SEND, H_FIN} host_state_t;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] ps1_r, ps2_r;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ps1_r <= '0;
      ps2_r <= '0;
    end else if (ce_in) begin
      ps1_r <= {link.config_complete, link.config_status_n};
      ps2_r <= ps1_r;
    end
  end

  // ---------------------------------------------------------------
  // apb slave and link driver
  // ---------------------------------------------------------------
  host_state_t         st_r, st_nxt;
  logic [CTRL_W-1:0]   ctrl_r, ctrl_nxt;
  logic [3:0]          div_r, div_nxt;
  logic [4:0]          cnt_r, cnt_nxt;
  logic                clk_r, clk_nxt;
  logic                req_n_r, req_n_nxt;
  logic [31:0]         dout_r, dout_nxt;
  logic                rdy_r, rdy_nxt;
  logic                err_r, err_nxt;
  logic [31:0]         rd_r, rd_nxt;
  logic                acc, mapped, fall;
  logic [3:0]          ratio;
  logic [4:0]          need;

  always_comb begin
    acc       = psel_in && penable_in;
    mapped    = (paddr_in == REG_CTRL) || (paddr_in == REG_CMD) || (paddr_in == REG_DATA) || (paddr_in == REG_STAT);
    ratio     = ratio_f(ctrl_r[MODE_WIDTH_LSB +: 2], ctrl_r[CTRL_DECOMP_BIT], ctrl_r[CTRL_SEC_BIT]); // R3
    need      = (st_r == H_FIN) ? 5'(POST_DONE_EDGES) : 5'(ratio);
    st_nxt    = st_r;
    ctrl_nxt  = ctrl_r;
    div_nxt   = div_r;
    cnt_nxt   = cnt_r;
    clk_nxt   = clk_r;
    req_n_nxt = req_n_r;
    dout_nxt  = dout_r;
    fall      = 1'b0;
    rdy_nxt   = 1'b0;
    err_nxt   = 1'b0;
    rd_nxt    = rd_r;
    case (st_r)
      H_REQ: begin
        req_n_nxt = 1'b0; // R14
        cnt_nxt   = cnt_r + 5'h1;
        if (cnt_r == 5'(REQ_LOW_CYC - 1)) begin
          st_nxt    = H_WAIT;
          req_n_nxt = 1'b1;
        end
      end
      H_WAIT: begin
        if (ps2_r[0] && !ps2_r[1]) begin // R7
          st_nxt = H_READY;
        end
      end
      H_READY: begin
        if (ps2_r[1]) begin
          st_nxt  = H_FIN;
          cnt_nxt = '0;
        end
      end
      H_SEND, H_FIN: begin
        div_nxt = div_r + 4'h1;
        if (div_r == 4'(CLK_DIV_HALF - 1)) begin
          div_nxt = '0;
          clk_nxt = !clk_r;
          fall    = clk_r;
        end
        if (fall) begin
          cnt_nxt = cnt_r + 5'h1;
          if (cnt_r + 5'h1 == need) begin // R4 R6 R13
            st_nxt = (st_r == H_FIN) ? H_IDLE : H_READY;
          end
        end
      end
      H_IDLE: begin
        st_nxt = H_IDLE;
      end
      default: begin
        st_nxt = H_IDLE;
      end
    endcase
    if (acc && !rdy_r) begin
      if (!(pwrite_in && paddr_in == REG_DATA) || st_r == H_READY) begin
        rdy_nxt = 1'b1;
        err_nxt = !mapped;
        rd_nxt  = '0;
        if (!pwrite_in && paddr_in == REG_CTRL) begin
          rd_nxt = 32'(ctrl_r);
        end else if (!pwrite_in && paddr_in == REG_STAT) begin
          rd_nxt[STAT_STATUS_BIT] = ps2_r[0];
          rd_nxt[STAT_DONE_BIT]   = ps2_r[1];
          rd_nxt[STAT_BUSY_BIT]   = (st_r != H_IDLE) && (st_r != H_READY);
          rd_nxt[STAT_READY_BIT]  = (st_r == H_READY);
        end
      end
    end
    if (acc && rdy_r && pwrite_in) begin
      if (paddr_in == REG_CTRL) begin
        ctrl_nxt = pwdata_in[CTRL_W-1:0]; // R1
      end else if (paddr_in == REG_CMD && pwdata_in[CMD_START_BIT]) begin
        st_nxt    = H_REQ;
        cnt_nxt   = '0;
        div_nxt   = '0;
        clk_nxt   = 1'b0;
        req_n_nxt = 1'b0;
      end else if (paddr_in == REG_DATA && st_r == H_READY) begin
        st_nxt   = H_SEND;
        cnt_nxt  = '0;
        div_nxt  = '0;
        clk_nxt  = 1'b0;
        dout_nxt = pwdata_in & mask_f(ctrl_r[MODE_WIDTH_LSB +: 2]); // R2
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r    <= H_IDLE;
      ctrl_r  <= '0;
      div_r   <= '0;
      cnt_r   <= '0;
      clk_r   <= 1'b0;
      req_n_r <= 1'b1;
      dout_r  <= '0;
      rdy_r   <= 1'b0;
      err_r   <= 1'b0;
      rd_r    <= '0;
    end else if (ce_in) begin
      st_r    <= st_nxt;
      ctrl_r  <= ctrl_nxt;
      div_r   <= div_nxt;
      cnt_r   <= cnt_nxt;
      clk_r   <= clk_nxt;
      req_n_r <= req_n_nxt;
      dout_r  <= dout_nxt;
      rdy_r   <= rdy_nxt;
      err_r   <= err_nxt;
      rd_r    <= rd_nxt;
    end
  end

  assign prdata_out            = rd_r;
  assign pready_out            = rdy_r;
  assign pslverr_out           = err_r;
  assign link.config_clock     = clk_r;
  assign link.config_data      = dout_r;
  assign link.config_request_n = req_n_r;
  assign link.mode_select_pins = ctrl_r[MODE_W-1:0];
  assign link.chip_enable_in_n = 1'b0;

endmodule

// ===== verif/cfg_loader_monitor.sv
// Purpose: wire checks on the load link
// Assumes: both ends are design code
// Notes:   HOLD_STD and HOLD_FAST are the hold counts handed to the device
`timescale 1ns/1ps
module cfg_loader_monitor
  import cfg_loader_pkg::*;
#(
  parameter int HOLD_STD  = 100,
  parameter int HOLD_FAST = 50
) (
  input wire logic        clock_in,
  input wire logic        rst_b_in,
  input wire logic        config_clock,
  input wire logic [31:0] config_data,
  input wire logic        config_request_n,
  input wire logic [3:0]  mode_select_pins,
  input wire logic        chain_enable_out_n,
  input wire logic        config_status_n,
  input wire logic        config_complete
);
  // ---
  // first hold length
  // ---
  logic [7:0] low_r;
  logic [7:0] low_nxt;
  logic       seen_r;
  logic       seen_nxt;
  logic [7:0] hold_lo;
  always_comb begin
    low_nxt  = config_status_n ? 8'h00 : low_r + 8'h01;
    hold_lo  = mode_select_pins[MODE_POR_FAST_BIT] ? 8'(HOLD_FAST - 1) : 8'(HOLD_STD - 1);
    seen_nxt = seen_r | config_status_n;
  end
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      low_r  <= 8'h00;
      seen_r <= 1'b0;
    end else begin
      low_r  <= low_nxt;
      seen_r <= seen_nxt;
    end
  end
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);
  chk_hold_length: assert property ($rose(config_status_n) && !seen_r |-> low_r inside {[hold_lo:hold_lo + 8'h07]})
    else $error("hold length off");
  chk_chain_after_done: assert property (!chain_enable_out_n |-> config_complete)
    else $error("chain low before complete");
  chk_done_drop_req: assert property ($fell(config_complete) |-> !config_request_n)
    else $error("complete dropped alone");
  chk_req_restart: assert property ($fell(config_request_n) && config_complete |-> ##[1:6] !config_status_n)
    else $error("no restart");
  chk_req_width: assert property ($fell(config_request_n) |-> (!config_request_n)[*8] ##[1:10] config_request_n)
    else $error("request width off");
  chk_data_held: assert property (config_clock |-> $stable(config_data))
    else $error("data moved while clock high");
  chk_half_period: assert property ($rose(config_clock) |-> config_clock[*8] ##1 !config_clock)
    else $error("clock half off");
  chk_narrow_lanes: assert property (mode_select_pins[1:0] == WIDTH_X8 && config_clock |-> config_data[31:8] == 24'h0)
    else $error("upper lanes used");
endmodule

// ===== verif/parallel_config_loader_tb.sv
// Purpose: self-checking run of both load ends
// Assumes: shortened device counts below
// Notes:   every width and feature mix is loaded in turn
`timescale 1ns/1ps
module parallel_config_loader_tb;
  import cfg_loader_pkg::*;
  localparam int LIM = 5000;
  logic        clock_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        ce_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic        decompress_en_in = 1'b0;
  logic        security_en_in = 1'b0;
  logic        user_init_opt_in = 1'b0;
  logic        user_init_clock_in = 1'b0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        user_mode_out;
  logic        io_voltage_sel_out;
  logic [31:0] config_word_out;
  logic        config_word_valid_out;
  logic [31:0] exp_q[$];
  int          err_count = 0;
  int          cmp_count = 0;
  int          rises = 0;
  int          cyc = 0;
  int          t_done = 0;

  cfg_link_if link ();
  cfg_load_device #(.POR_FAST_CYC_P(24'h32), .POR_STD_CYC_P(24'h64), .CD2UM_CYC_P(24'h28), .USER_INIT_PERIODS_P(14'hA))
    u_cfg_load_device (.clock_in, .rst_b_in, .ce_in, .decompress_en_in, .security_en_in, .user_init_opt_in,
    .user_init_clock_in, .user_mode_out, .io_voltage_sel_out, .config_word_out, .config_word_valid_out, .link(link));
  cfg_load_host u_cfg_load_host (.clock_in, .rst_b_in, .ce_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .link(link));
  cfg_loader_monitor #(.HOLD_STD(100), .HOLD_FAST(50)) u_cfg_loader_monitor (.clock_in, .rst_b_in,
    .config_clock(link.config_clock), .config_data(link.config_data), .config_request_n(link.config_request_n),
    .mode_select_pins(link.mode_select_pins), .chain_enable_out_n(link.chain_enable_out_n),
    .config_status_n(link.config_status_n), .config_complete(link.config_complete));

  always #5 clock_in = ~clock_in;
  always #27 user_init_clock_in = ~user_init_clock_in;
  always @(posedge clock_in) cyc++;
  always @(posedge link.config_complete) t_done = cyc;
  // ---
  // model: captured words against written ones
  // ---
  always @(posedge link.config_clock) begin
    rises++;
    #1;
    if (config_word_valid_out === 1'b1) begin
      check(config_word_out, exp_q.pop_front());
    end
  end

  function automatic int ratio(input int w, input bit dc, input bit sc);
    if (w == 0) return dc ? 2 : 1;
    if (dc) return w == 1 ? 4 : 8;
    if (sc) return w == 1 ? 2 : 4;
    return 1;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic stop_hang;
    err_count++;
    end_of_test();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge clock_in);
    psel_in    <= 1'b1;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < LIM);
    if (n >= LIM) stop_hang();
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic poll(input int b);
    logic [31:0] rd;
    logic        er;
    int          n;
    n = 0;
    rd = 32'h0;
    while (rd[b] !== 1'b1) begin
      apb(1'b0, REG_STAT, 32'h0, rd, er);
      n++;
      if (n > LIM) stop_hang();
    end
  endtask

  initial begin
    logic [31:0] rd;
    logic [31:0] d;
    logic [31:0] msk;
    logic [5:0]  ctrl;
    logic        er;
    bit          uo;
    int          n;
    int          w;
    int          r;
    int          nv;
    void'($urandom(32'hE8EF6F65));
    repeat (6) @(posedge clock_in);
    rst_b_in <= 1'b1;
    n = 0;
    while (link.config_status_n !== 1'b1 && n < LIM) begin
      @(posedge clock_in);
      n++;
    end
    check(32'(n >= 99 && n <= 110), 32'h1);
    apb(1'b0, 8'h10, 32'h0, rd, er);
    check(rd, 32'h0);
    check(32'(er), 32'h1);
    $display("test hold done");
    for (int m = 0; m < 12; m++) begin
      w = m >> 2;
      r = ratio(w, m[1], m[0]);
      nv = CFG_BYTES >> w;
      msk = (w == 2) ? 32'hFFFFFFFF : (32'h100 << (8 * w)) - 32'h1;
      ctrl = {m[0], m[1], m[2], 1'b0, w[1:0]};
      uo = m[0] ^ m[1];
      decompress_en_in <= m[1];
      security_en_in   <= m[0];
      user_init_opt_in <= uo;
      apb(1'b1, REG_CTRL, {26'h0, ctrl}, rd, er);
      apb(1'b0, REG_CTRL, 32'h0, rd, er);
      check(rd, {26'h0, ctrl});
      apb(1'b1, REG_CMD, 32'h1, rd, er);
      poll(STAT_READY_BIT);
      check(32'(io_voltage_sel_out), 32'(m[2]));
      rises = 0;
      for (int i = 0; i < nv; i++) begin
        if (i == nv - 1) begin
          apb(1'b0, REG_STAT, 32'h0, rd, er);
          check(32'(rd[STAT_DONE_BIT]), 32'h0);
        end
        d = $urandom;
        exp_q.push_back(d & msk);
        apb(1'b1, REG_DATA, d, rd, er);
      end
      poll(STAT_DONE_BIT);
      n = 0;
      while (user_mode_out !== 1'b1 && n < LIM) begin
        @(posedge clock_in);
        n++;
      end
      if (n >= LIM) stop_hang();
      n = cyc - t_done;
      check(32'(uo ? n >= CD2CU_CYC + 54 : n >= 40 && n <= 99), 32'h1);
      check(rises, nv * r + 2);
      check(exp_q.size(), 0);
      check(32'(link.chain_enable_out_n), 32'h0);
      $display("test mode %0d done", m);
    end
    rst_b_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    rst_b_in <= 1'b1;
    apb(1'b1, REG_CTRL, 32'(1 << MODE_POR_FAST_BIT), rd, er);
    n = 4;
    while (link.config_status_n !== 1'b1 && n < LIM) begin
      @(posedge clock_in);
      n++;
    end
    check(32'(n >= 49 && n <= 60), 32'h1);
    $display("test fast hold done");
    end_of_test();
  end
endmodule
